// ===== uart_host_bus_pkg.sv
// constants for the uart host bus port: widths, reset values, state codes
// assumes all host pins are synchronous to clk_in
package uart_host_bus_pkg;
  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int          INDEX_W     = 3;
  localparam int          DATA_W      = 8;
  localparam logic [2:0]  INDEX_RST   = 3'h0;
  localparam logic [7:0]  DATA_RST    = 8'h00;
  localparam logic [2:0]  SEL_RST     = 3'h0;
  localparam int          SEL_HIGH_A  = 0;
  localparam int          SEL_HIGH_B  = 1;
  localparam int          SEL_LOW_C   = 2;

  // ----------------------------------------------------------------
  // access sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } access_state_e;
endpackage

// ===== uart_host_bus_port.sv
// host side parallel bus port: decodes selects and strobes, drives the data bus
// assumes host pins are synchronous to clk_in; register storage sits outside
`timescale 1ns/1ps
`default_nettype none
module uart_host_bus_port #(
  parameter int INDEX_W = uart_host_bus_pkg::INDEX_W,
  parameter int DATA_W  = uart_host_bus_pkg::DATA_W
) (
  input  wire logic               clk_in,
  input  wire logic               rstn_in,
  input  wire logic               reset_in,
  input  wire logic [INDEX_W-1:0] register_index_in,
  input  wire logic               select_high_a_in,
  input  wire logic               select_high_b_in,
  input  wire logic               select_low_c_in,
  input  wire logic               address_latch_strobe_in,
  input  wire logic               read_strobe_high_in,
  input  wire logic               read_strobe_low_in,
  input  wire logic               write_strobe_high_in,
  input  wire logic               write_strobe_low_in,
  input  wire logic [DATA_W-1:0]  host_data_bus_in,
  output logic      [DATA_W-1:0]  host_data_bus_out,
  output logic                    host_data_bus_oe_out,
  input  wire logic [DATA_W-1:0]  reg_read_data_in,
  output logic      [INDEX_W-1:0] reg_index_out,
  output logic                    reg_read_out,
  output logic                    reg_write_out,
  output logic      [DATA_W-1:0]  reg_write_data_out
);
  // ----------------------------------------------------------------
  // address latch
  // ----------------------------------------------------------------
  logic [INDEX_W-1:0] lat_index;
  logic [2:0]         lat_sel;
  logic               prev_as;
  logic [INDEX_W-1:0] next_lat_index;
  logic [2:0]         next_lat_sel;
  logic [2:0]         live_sel;
  logic [2:0]         eff_sel;
  logic [INDEX_W-1:0] eff_index;
  logic               as_rise;
  logic               sel_ok;

  // transparent while the strobe is low, frozen from its rising edge on;
  // this lets a host tie the strobe low and still use live address
  // limitation: held values still apply for one cycle after the strobe
  // falls, since the select mux follows the delayed copy of the strobe
  always_comb begin
    live_sel  = {select_low_c_in, select_high_b_in, select_high_a_in};
    as_rise   = address_latch_strobe_in & ~prev_as;
    eff_sel   = prev_as ? lat_sel : live_sel;
    eff_index = prev_as ? lat_index : register_index_in;
    next_lat_index = as_rise ? register_index_in : lat_index;
    next_lat_sel   = as_rise ? live_sel : lat_sel;
    sel_ok = eff_sel[uart_host_bus_pkg::SEL_HIGH_A] &
             eff_sel[uart_host_bus_pkg::SEL_HIGH_B] &
             ~eff_sel[uart_host_bus_pkg::SEL_LOW_C];
    if (reset_in) begin
      next_lat_index = uart_host_bus_pkg::INDEX_RST;
      next_lat_sel   = uart_host_bus_pkg::SEL_RST;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lat_index <= uart_host_bus_pkg::INDEX_RST;
      lat_sel   <= uart_host_bus_pkg::SEL_RST;
      prev_as   <= 1'b0;
    end else begin
      lat_index <= next_lat_index;
      lat_sel   <= next_lat_sel;
      prev_as   <= reset_in ? 1'b0 : address_latch_strobe_in;
    end
  end

  // ----------------------------------------------------------------
  // access sequencer and outputs
  // ----------------------------------------------------------------
  uart_host_bus_pkg::access_state_e state;
  uart_host_bus_pkg::access_state_e next_state;
  logic               rd_req;
  logic               wr_req;
  logic [DATA_W-1:0]  next_data_out;
  logic               next_oe;
  logic [INDEX_W-1:0] next_index;
  logic               next_read;
  logic               next_write;
  logic [DATA_W-1:0]  next_wdata;

  // one pulse per strobe assertion; strobes must drop to idle between
  // accesses, so a held strobe never repeats a side-effecting access;
  // a write strobe raised during a read waits until the read has ended
  always_comb begin
    rd_req = sel_ok & (read_strobe_high_in | ~read_strobe_low_in);
    wr_req = sel_ok & (write_strobe_high_in | ~write_strobe_low_in);
    case (state)
      uart_host_bus_pkg::ST_IDLE: begin
        if (rd_req) next_state = uart_host_bus_pkg::ST_READ;
        else if (wr_req) next_state = uart_host_bus_pkg::ST_WRITE;
        else next_state = uart_host_bus_pkg::ST_IDLE;
      end
      uart_host_bus_pkg::ST_READ: begin
        next_state = rd_req ? uart_host_bus_pkg::ST_READ : uart_host_bus_pkg::ST_IDLE;
      end
      uart_host_bus_pkg::ST_WRITE: begin
        next_state = wr_req ? uart_host_bus_pkg::ST_WRITE : uart_host_bus_pkg::ST_IDLE;
      end
      default: next_state = uart_host_bus_pkg::ST_IDLE;
    endcase
    if (reset_in) next_state = uart_host_bus_pkg::ST_IDLE;
    next_index = reset_in ? uart_host_bus_pkg::INDEX_RST : eff_index;
    next_oe    = (next_state == uart_host_bus_pkg::ST_READ);
    next_read  = next_oe & (state != uart_host_bus_pkg::ST_READ);
    next_write = (next_state == uart_host_bus_pkg::ST_WRITE) &&
                 (state != uart_host_bus_pkg::ST_WRITE);
    // bits pass straight through, bit 0 stays the lsb
    next_data_out = next_oe ? reg_read_data_in : uart_host_bus_pkg::DATA_RST;
    next_wdata    = next_write ? host_data_bus_in : reg_write_data_out;
    if (reset_in) next_wdata = uart_host_bus_pkg::DATA_RST;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state                <= uart_host_bus_pkg::ST_IDLE;
      host_data_bus_out    <= uart_host_bus_pkg::DATA_RST;
      host_data_bus_oe_out <= 1'b0;
      reg_index_out        <= uart_host_bus_pkg::INDEX_RST;
      reg_read_out         <= 1'b0;
      reg_write_out        <= 1'b0;
      reg_write_data_out   <= uart_host_bus_pkg::DATA_RST;
    end else begin
      state                <= next_state;
      host_data_bus_out    <= next_data_out;
      host_data_bus_oe_out <= next_oe;
      reg_index_out        <= next_index;
      reg_read_out         <= next_read;
      reg_write_out        <= next_write;
      reg_write_data_out   <= next_wdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // outputs are registered, so most properties look one edge ahead;
  // reset_in is a level, so antecedents that start or hold an access leave its cycles out

  a_read_drives_bus: assert property (
    !reset_in && state == uart_host_bus_pkg::ST_IDLE && rd_req
    |=> host_data_bus_oe_out && reg_read_out) else $error("read not driven");
  a_low_read_level: assert property (
    !reset_in && sel_ok && !read_strobe_low_in && state == uart_host_bus_pkg::ST_READ
    |=> host_data_bus_oe_out) else $error("bus dropped during low read");
  a_high_write_event: assert property (
    !reset_in && state == uart_host_bus_pkg::ST_IDLE && sel_ok && !rd_req
    && $rose(write_strobe_high_in)
    |=> reg_write_out ##1 !reg_write_out) else $error("high write edge missed");
  a_write_data_taken: assert property (
    !reset_in && state == uart_host_bus_pkg::ST_IDLE && wr_req && !rd_req
    |=> reg_write_out && reg_write_data_out == $past(host_data_bus_in))
    else $error("write data not taken");
  a_low_write_level: assert property (
    !reset_in && state == uart_host_bus_pkg::ST_IDLE && sel_ok && !rd_req
    && !write_strobe_low_in |=> reg_write_out) else $error("low write ignored");
  a_select_gates_bus: assert property (
    $rose(host_data_bus_oe_out) |-> $past(sel_ok)) else $error("read while unselected");
  a_low_select_needed: assert property (
    !reset_in && state == uart_host_bus_pkg::ST_IDLE && !prev_as && select_low_c_in
    |=> !host_data_bus_oe_out && !reg_write_out) else $error("low select ignored");
  a_latch_capture: assert property (
    !reset_in && as_rise ##1 address_latch_strobe_in && !reset_in
    |=> reg_index_out == $past(register_index_in, 2)) else $error("latched index lost");
  a_live_index: assert property (
    !reset_in && !prev_as |=> reg_index_out == $past(register_index_in))
    else $error("index not followed");
  a_bus_released: assert property (
    !$past(rd_req) |-> !host_data_bus_oe_out)
    else $error("bus driven outside read");
  a_read_stands: assert property (
    !reset_in && host_data_bus_oe_out && !rd_req
    |=> !host_data_bus_oe_out) else $error("bus held after read");
  a_reset_clears: assert property (
    reset_in |=> !host_data_bus_oe_out && !reg_read_out && !reg_write_out
    && reg_index_out == uart_host_bus_pkg::INDEX_RST) else $error("reset incomplete");
  a_unselected_quiet: assert property (
    state == uart_host_bus_pkg::ST_IDLE && !sel_ok
    |=> !host_data_bus_oe_out && !reg_write_out) else $error("strobe while unselected");
  a_read_data_path: assert property (
    !reset_in && state != uart_host_bus_pkg::ST_WRITE && rd_req
    |=> host_data_bus_out == $past(reg_read_data_in)) else $error("read data not passed");
  a_read_wins: assert property (
    !reset_in && state == uart_host_bus_pkg::ST_IDLE && rd_req && wr_req
    |=> !reg_write_out) else $error("write taken with read");
  a_write_in_read: assert property (
    !reset_in && state == uart_host_bus_pkg::ST_READ && wr_req
    |=> !reg_write_out) else $error("write taken while reading");
  a_read_pulse_once: assert property (
    reg_read_out |=> !reg_read_out) else $error("read pulse repeated");
  a_write_pulse_once: assert property (
    reg_write_out |=> !reg_write_out) else $error("write pulse repeated");
  a_write_data_holds: assert property (
    !reg_write_out && !$past(reset_in) |-> $stable(reg_write_data_out))
    else $error("write data moved");
  a_latched_select: assert property (
    !reset_in && as_rise |=> sel_ok == $past(sel_ok)) else $error("latched select lost");
  a_reset_data_clear: assert property (
    reset_in |=> host_data_bus_out == uart_host_bus_pkg::DATA_RST
    && reg_write_data_out == uart_host_bus_pkg::DATA_RST) else $error("reset left data");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  c_read: cover property (reg_read_out ##1 host_data_bus_oe_out[*2]);
  c_write: cover property (reg_write_out);
  c_latched_write: cover property (as_rise ##[1:4] reg_write_out);
  c_high_read: cover property (
    state == uart_host_bus_pkg::ST_IDLE && sel_ok && read_strobe_high_in ##1 reg_read_out);
  c_reset_in_read: cover property (host_data_bus_oe_out && reset_in);
endmodule // uart_host_bus_port
`default_nettype wire

// ===== reg_store_model.sv
// register storage behind the host port: eight byte-wide registers
// assumes one clock; written on the port's one-cycle write pulse
`timescale 1ns/1ps
`default_nettype none
module reg_store_model (
  input  wire logic       clk_in,
  input  wire logic [2:0] index_in,
  input  wire logic       write_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out
);
  logic [7:0] mem [8];
  initial for (int i = 0; i < 8; i++) mem[i] = 8'h00;
  assign data_out = mem[index_in];
  always @(posedge clk_in) if (write_in) mem[index_in] <= data_in;
endmodule // reg_store_model
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the uart host bus port
// assumes the port answers one edge after a strobe, as its contract states
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk_in = 1'b0, rstn_in = 1'b0, reset_in = 1'b0;
  logic [2:0] idx = 3'h0;
  logic       sa = 1'b0, sb = 1'b0, sc = 1'b1, als = 1'b0;
  logic       rh = 1'b0, rl = 1'b1, wh = 1'b0, wl = 1'b1;
  logic [7:0] hdrv = 8'h00, dout, wdat, rdat, exp_mem [8];
  logic [2:0] ridx;
  logic       oe, rrd, rwr;
  wire  [7:0] host_bus = oe ? dout : hdrv;
  int         n_errors = 0, comparisons = 0, cycles = 0;
  uart_host_bus_port DUT (.clk_in(clk_in), .rstn_in(rstn_in), .reset_in(reset_in),
    .register_index_in(idx), .select_high_a_in(sa), .select_high_b_in(sb),
    .select_low_c_in(sc), .address_latch_strobe_in(als), .read_strobe_high_in(rh),
    .read_strobe_low_in(rl), .write_strobe_high_in(wh), .write_strobe_low_in(wl),
    .host_data_bus_in(host_bus), .host_data_bus_out(dout), .host_data_bus_oe_out(oe),
    .reg_read_data_in(rdat), .reg_index_out(ridx), .reg_read_out(rrd),
    .reg_write_out(rwr), .reg_write_data_out(wdat));
  reg_store_model store (.clk_in(clk_in), .index_in(ridx), .write_in(rwr),
    .data_in(wdat), .data_out(rdat));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  initial forever #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // kind 0 read low, 1 read high, 2 write low, 3 write high; sel is {c, b, a}
  task automatic acc(input int k, input logic [2:0] i, input logic [7:0] d,
                     input logic [2:0] s);
    {sc, sb, sa} = s;
    idx = i;
    hdrv = d;
    rl = (k != 0);
    rh = (k == 1);
    wl = (k != 2);
    wh = (k == 3);
    @(negedge clk_in);
  endtask
  task automatic rel();
    rl = 1'b1;
    rh = 1'b0;
    wl = 1'b1;
    wh = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_write();
    for (int i = 0; i < 8; i++) begin
      exp_mem[i] = (8'h01 << i) ^ 8'hA5;
      acc(2 + i % 2, i[2:0], exp_mem[i], 3'h3);
      check("wr_pulse", {7'h00, rwr}, 8'h01);
      check("wr_data", wdat, exp_mem[i]);
      check("wr_index", {5'h00, ridx}, i[7:0]);
      @(negedge clk_in);
      check("wr_pulse_end", {7'h00, rwr}, 8'h00);
      rel();
    end
  endtask
  task automatic t_read();
    for (int i = 7; i >= 0; i--) begin
      acc(i % 2, i[2:0], 8'h5A, 3'h3);
      check("rd_oe", {7'h00, oe}, 8'h01);
      check("rd_pulse", {7'h00, rrd}, 8'h01);
      @(negedge clk_in);
      check("rd_data", dout, exp_mem[i]);
      rel();
      check("rd_release", {7'h00, oe}, 8'h00);
    end
  endtask
  task automatic t_unselected();
    logic [2:0] bad [3] = '{3'h2, 3'h1, 3'h7};
    for (int j = 0; j < 3; j++) begin
      acc(j % 2, 3'h4, 8'hFF, bad[j]);
      check("unsel_oe", {7'h00, oe}, 8'h00);
      rel();
      acc(2 + j % 2, 3'h4, 8'hFF, bad[j]);
      check("unsel_wr", {7'h00, rwr}, 8'h00);
      rel();
    end
  endtask
  task automatic t_latch();
    {sc, sb, sa} = 3'h3;
    idx = 3'h5;
    als = 1'b1;
    @(negedge clk_in);
    acc(0, 3'h2, 8'h00, 3'h2);
    check("latch_oe", {7'h00, oe}, 8'h01);
    @(negedge clk_in);
    check("latch_data", dout, exp_mem[5]);
    rel();
    als = 1'b0;
  endtask
  task automatic t_reset();
    acc(1, 3'h3, 8'h00, 3'h3);
    reset_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check("rst_oe", {7'h00, oe}, 8'h00);
    check("rst_data", dout, 8'h00);
    reset_in = 1'b0;
    rel();
  endtask
  task automatic finish_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_in);
    rstn_in = 1'b1;
    @(negedge clk_in);
    check("init_flags", {5'h00, oe, rrd, rwr}, 8'h00);
    check("init_data", dout, 8'h00);
    t_write();
    t_read();
    t_unselected();
    t_latch();
    t_reset();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
